// File: vqs_pkg.sv
`default_nettype none
package vqs_pkg;
    // Header fields seen by the ingress header processor
    localparam int HDR_PORT_LSB = 0;
    localparam int HDR_MCAST_BIT = 15;
    // Field rewritten by the egress header editor
    localparam int EDIT_PORT_LSB = 8;
    // Legal size of a first fragment, in bytes
    localparam logic [8:0] FIRST_MIN_BYTES = 9'h040;
    localparam logic [8:0] FIRST_MAX_BYTES = 9'h180;
    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } vqs_tx_state_t;
endpackage : vqs_pkg
`default_nettype wire

// File: vqs_switch.sv
`timescale 1ns/1ps
`default_nettype none
module vqs_switch #(
    parameter int DATA_W = 64,
    parameter int LEN_W = 9,
    parameter int DEPTH = 16,
    parameter int NSLICE = 2,
    parameter int PPS = 2,
    parameter int VQD = 4,
    parameter int OQD = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic in_first,
    input wire logic in_last,
    input wire logic [LEN_W-1:0] in_len,
    input wire logic [DATA_W-1:0] in_data,
    output logic in_ready,
    output logic pkt_drop,
    output logic tx_valid,
    output logic tx_first,
    output logic tx_last,
    output logic [$clog2(NSLICE*PPS)-1:0] tx_port,
    output logic [LEN_W-1:0] tx_len,
    output logic [DATA_W-1:0] tx_data,
    input wire logic tx_ready
);
    import vqs_pkg::*;
    localparam int NP = NSLICE * PPS;
    localparam int PW = $clog2(NP);
    localparam int AW = $clog2(DEPTH);
    localparam int RW = $clog2(NP + 1);
    localparam int VW = $clog2(VQD);
    localparam int OW = $clog2(OQD);
    localparam int SW = (NSLICE > 1) ? $clog2(NSLICE) : 1;
    localparam int DW = AW + NP;

    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] sdata;
        logic [DEPTH-1:0][LEN_W-1:0] slen;
        logic [DEPTH-1:0][AW-1:0] slink;
        logic [DEPTH-1:0] slast;
        logic [DEPTH-1:0][RW-1:0] srefs;
        logic in_ready;
        logic in_pkt;
        logic in_drop;
        logic drop;
        logic [AW-1:0] in_head;
        logic [AW-1:0] in_tail;
        logic [NP-1:0] in_mask;
        logic pend;
        logic [AW-1:0] pend_head;
        logic [NP-1:0] pend_rem;
        logic [NSLICE-1:0][VQD-1:0][DW-1:0] per_destination_input_queue;
        logic [NSLICE-1:0][VW-1:0] voq_rd;
        logic [NSLICE-1:0][VW-1:0] voq_wr;
        logic [NSLICE-1:0][VW:0] voq_cnt;
        logic [SW-1:0] xrr;
        logic xb_valid;
        logic [AW-1:0] xb_head;
        logic [NP-1:0] xb_mask;
        logic [NP-1:0][OW:0] oq_used;
        logic [NP-1:0][OQD-1:0][AW-1:0] oq;
        logic [NP-1:0][OW-1:0] oq_rd;
        logic [NP-1:0][OW-1:0] oq_wr;
        logic [NP-1:0][OW:0] oq_cnt;
        vqs_tx_state_t txs;
        logic [PW-1:0] orr;
        logic [PW-1:0] cur_port;
        logic [AW-1:0] cur;
        logic cur_first;
        logic tx_valid;
        logic tx_first;
        logic tx_last;
        logic [PW-1:0] tx_port;
        logic [LEN_W-1:0] tx_len;
        logic [DATA_W-1:0] tx_data;
    } vqs_state_t;

    vqs_state_t s;
    vqs_state_t next_s;

    function automatic logic [RW-1:0] pop_count(input logic [NP-1:0] m);
        logic [RW-1:0] c;
        c = '0;
        for (int i = 0; i < NP; i++) begin
            c = c + RW'(m[i]);
        end
        return c;
    endfunction : pop_count

    function automatic logic [NP-1:0] slice_bits(input int sl);
        return NP'({PPS{1'b1}}) << (sl * PPS);
    endfunction : slice_bits

    // Header processor: multicast flag selects a port mask, else a port index
    function automatic logic [NP-1:0] hdr_dest(input logic [DATA_W-1:0] d);
        if (d[HDR_MCAST_BIT]) begin
            return d[NP-1:0];
        end
        return NP'(1) << d[HDR_PORT_LSB +: PW];
    endfunction : hdr_dest

    logic take;
    logic hdr_ok;
    logic [NP-1:0] hdr_mask;
    logic free_any;
    logic [AW-1:0] free_idx;
    logic [NSLICE-1:0] credit_req;
    logic [NSLICE-1:0] credit_ok;

    assign take = in_valid && s.in_ready;
    assign hdr_mask = hdr_dest(in_data);
    assign hdr_ok = (in_len >= FIRST_MIN_BYTES) && (in_len <= FIRST_MAX_BYTES) && (hdr_mask != '0);

    always_comb begin
        free_any = 1'b0;
        free_idx = '0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (s.srefs[i] == '0) begin
                free_any = 1'b1;
                free_idx = AW'(i);
            end
        end
    end

    // Request stands while a queue holds anything; grant needs room in every target
    always_comb begin
        for (int sl = 0; sl < NSLICE; sl++) begin
            credit_req[sl] = s.voq_cnt[sl] != '0;
            credit_ok[sl] = credit_req[sl];
            for (int p = 0; p < NP; p++) begin
                if (s.per_destination_input_queue[sl][s.voq_rd[sl]][p] && s.oq_used[p] == (OW+1)'(OQD)) begin
                    credit_ok[sl] = 1'b0;
                end
            end
        end
    end

    always_comb begin
        logic found;
        logic [DATA_W-1:0] d;
        int idx;
        int nfree;
        next_s = s;
        found = 1'b0;
        d = '0;
        idx = 0;
        nfree = 0;
        next_s.drop = 1'b0;
        if (s.tx_valid && tx_ready) begin
            next_s.tx_valid = 1'b0;
        end
        // Ingress port group and shared store write
        if (take) begin
            if (in_first) begin
                if (!hdr_ok) begin
                    next_s.drop = 1'b1;
                    next_s.in_drop = !in_last;
                    next_s.in_pkt = 1'b0;
                end else begin
                    next_s.sdata[free_idx] = in_data;
                    next_s.slen[free_idx] = in_len;
                    next_s.slast[free_idx] = in_last;
                    next_s.srefs[free_idx] = pop_count(hdr_mask);
                    next_s.in_head = free_idx;
                    next_s.in_tail = free_idx;
                    next_s.in_mask = hdr_mask;
                    next_s.in_pkt = !in_last;
                    next_s.in_drop = 1'b0;
                    if (in_last) begin
                        next_s.pend = 1'b1;
                        next_s.pend_head = free_idx;
                        next_s.pend_rem = hdr_mask;
                    end
                end
            end else if (s.in_drop) begin
                next_s.in_drop = !in_last;
            end else if (s.in_pkt) begin
                next_s.sdata[free_idx] = in_data;
                next_s.slen[free_idx] = in_len;
                next_s.slast[free_idx] = in_last;
                next_s.srefs[free_idx] = pop_count(s.in_mask);
                next_s.slink[s.in_tail] = free_idx;
                next_s.in_tail = free_idx;
                if (in_last) begin
                    next_s.in_pkt = 1'b0;
                    next_s.pend = 1'b1;
                    next_s.pend_head = s.in_head;
                    next_s.pend_rem = s.in_mask;
                end
            end else begin
                next_s.drop = 1'b1;
            end
        end
        // Crossbar: round robin over queues that hold credit
        next_s.xb_valid = 1'b0;
        for (int k = 0; k < NSLICE; k++) begin
            idx = (int'(s.xrr) + k) % NSLICE;
            if (!found && credit_ok[idx]) begin
                found = 1'b1;
                next_s.xb_valid = 1'b1;
                next_s.xb_head = s.per_destination_input_queue[idx][s.voq_rd[idx]][DW-1:NP];
                next_s.xb_mask = s.per_destination_input_queue[idx][s.voq_rd[idx]][NP-1:0];
                next_s.voq_rd[idx] = s.voq_rd[idx] + VW'(1);
                next_s.voq_cnt[idx] = s.voq_cnt[idx] - (VW+1)'(1);
                next_s.xrr = SW'((idx + 1) % NSLICE);
                for (int p = 0; p < NP; p++) begin
                    if (s.per_destination_input_queue[idx][s.voq_rd[idx]][p]) begin
                        next_s.oq_used[p] = next_s.oq_used[p] + (OW+1)'(1);
                    end
                end
            end
        end
        // Ingress replicator: one enqueue per destination slice; a full queue stalls it
        found = 1'b0;
        for (int sl = 0; sl < NSLICE; sl++) begin
            if (s.pend && !found && (s.pend_rem & slice_bits(sl)) != '0) begin
                found = 1'b1;
                if (s.voq_cnt[sl] != (VW+1)'(VQD)) begin
                    next_s.per_destination_input_queue[sl][s.voq_wr[sl]] = {s.pend_head, s.pend_rem & slice_bits(sl)};
                    next_s.voq_wr[sl] = s.voq_wr[sl] + VW'(1);
                    next_s.voq_cnt[sl] = next_s.voq_cnt[sl] + (VW+1)'(1);
                    next_s.pend_rem = s.pend_rem & ~slice_bits(sl);
                    next_s.pend = (s.pend_rem & ~slice_bits(sl)) != '0;
                end
            end
        end
        // Egress replicator: room was reserved at grant, so writes never overflow
        for (int p = 0; p < NP; p++) begin
            if (s.xb_valid && s.xb_mask[p]) begin
                next_s.oq[p][s.oq_wr[p]] = s.xb_head;
                next_s.oq_wr[p] = s.oq_wr[p] + OW'(1);
                next_s.oq_cnt[p] = s.oq_cnt[p] + (OW+1)'(1);
            end
        end
        // Output queue scheduler and store read-out
        found = 1'b0;
        unique case (s.txs)
            TX_IDLE: begin
                for (int k = 0; k < NP; k++) begin
                    idx = (int'(s.orr) + k) % NP;
                    if (!found && s.oq_cnt[idx] != '0) begin
                        found = 1'b1;
                        next_s.cur = s.oq[idx][s.oq_rd[idx]];
                        next_s.cur_port = PW'(idx);
                        next_s.cur_first = 1'b1;
                        next_s.oq_rd[idx] = s.oq_rd[idx] + OW'(1);
                        next_s.oq_cnt[idx] = next_s.oq_cnt[idx] - (OW+1)'(1);
                        next_s.oq_used[idx] = next_s.oq_used[idx] - (OW+1)'(1);
                        next_s.orr = PW'((idx + 1) % NP);
                        next_s.txs = TX_SEND;
                    end
                end
            end
            TX_SEND: begin
                if (!s.tx_valid || tx_ready) begin
                    d = s.sdata[s.cur];
                    if (s.cur_first) begin
                        d[HDR_MCAST_BIT] = 1'b0;
                        d[EDIT_PORT_LSB +: PW] = s.cur_port;
                    end
                    next_s.tx_valid = 1'b1;
                    next_s.tx_data = d;
                    next_s.tx_first = s.cur_first;
                    next_s.tx_last = s.slast[s.cur];
                    next_s.tx_len = s.slen[s.cur];
                    next_s.tx_port = s.cur_port;
                    next_s.srefs[s.cur] = s.srefs[s.cur] - RW'(1);
                    next_s.cur = s.slink[s.cur];
                    next_s.cur_first = 1'b0;
                    if (s.slast[s.cur]) begin
                        next_s.txs = TX_IDLE;
                    end
                end
            end
        endcase
        // Ready only with no descriptor pending and a free slot after this cycle
        for (int i = 0; i < DEPTH; i++) begin
            nfree = nfree + int'(next_s.srefs[i] == '0);
        end
        next_s.in_ready = !next_s.pend && (nfree > 0);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready = s.in_ready;
    assign pkt_drop = s.drop;
    assign tx_valid = s.tx_valid;
    assign tx_first = s.tx_first;
    assign tx_last = s.tx_last;
    assign tx_port = s.tx_port;
    assign tx_len = s.tx_len;
    assign tx_data = s.tx_data;

    a_ready_has_slot: assert property (@(posedge mclk) disable iff (!rst_n) in_ready |-> free_any && !s.pend) else $error("Ready without free slot");
    a_bad_first_drop: assert property (@(posedge mclk) disable iff (!rst_n) take && in_first && !hdr_ok |=> pkt_drop && s.srefs[$past(free_idx)] == '0) else $error("Bad first fragment stored");
    a_first_dest: assert property (@(posedge mclk) disable iff (!rst_n) take && in_first && hdr_ok && !s.pend |=> s.in_mask == $past(hdr_mask) && s.in_head == $past(free_idx)) else $error("Destination not taken");
    a_frag_linked: assert property (@(posedge mclk) disable iff (!rst_n) take && !in_first && s.in_pkt && !s.in_drop |=> s.slink[$past(s.in_tail)] == $past(free_idx) && s.in_mask == $past(s.in_mask)) else $error("Fragment not linked");
    a_desc_made: assert property (@(posedge mclk) disable iff (!rst_n) take && in_last && (in_first ? hdr_ok : (s.in_pkt && !s.in_drop)) |=> s.pend && !in_ready) else $error("No descriptor");
    a_tx_hold: assert property (@(posedge mclk) disable iff (!rst_n) tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("Output dropped under stall");
    a_edit_first: assert property (@(posedge mclk) disable iff (!rst_n) tx_valid && tx_first |-> !tx_data[HDR_MCAST_BIT] && tx_data[EDIT_PORT_LSB +: PW] == tx_port) else $error("First fragment not edited");

    for (genvar g = 0; g < NSLICE; g++) begin : g_slice_chk
        a_copy_in_slice: assert property (@(posedge mclk) disable iff (!rst_n) s.voq_cnt[g] == $past(s.voq_cnt[g]) + 1 |-> (s.per_destination_input_queue[g][$past(s.voq_wr[g])][NP-1:0] & ~slice_bits(g)) == '0) else $error("Copy in wrong queue");
        a_wait_holds: assert property (@(posedge mclk) disable iff (!rst_n) credit_req[g] && !credit_ok[g] |=> s.voq_rd[g] == $past(s.voq_rd[g]) && credit_req[g]) else $error("Head moved without credit");
    end

    for (genvar g = 0; g < NP; g++) begin : g_port_chk
        a_credit_bound: assert property (@(posedge mclk) disable iff (!rst_n) s.oq_used[g] <= (OW+1)'(OQD) && s.oq_cnt[g] <= s.oq_used[g]) else $error("Credit overrun");
        a_xbar_to_oq: assert property (@(posedge mclk) disable iff (!rst_n) s.xb_valid && s.xb_mask[g] |=> s.oq[g][$past(s.oq_wr[g])] == $past(s.xb_head)) else $error("Copy missed output queue");
    end
endmodule : vqs_switch
`default_nettype wire

// File: vqs_card_sink.sv
`timescale 1ns/1ps
`default_nettype none
module vqs_card_sink (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] mode,
    output logic tx_ready
);
    logic [1:0] phase;
    // Mode 0 takes every fragment, 1 takes one in three, 2 holds off to build backpressure
    always @(negedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            tx_ready <= (mode == 2'h0) || (mode == 2'h1 && phase == 2'h0);
        end
    end
endmodule : vqs_card_sink
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0;
    logic rst_n, in_valid, in_first, in_last, in_ready, pkt_drop;
    logic [8:0] in_len, tx_len;
    logic [63:0] in_data, tx_data;
    logic tx_valid, tx_first, tx_last, tx_ready;
    logic [1:0] tx_port, sink_mode;
    int mismatches = 0, samples_checked = 0, drops = 0, cycles = 0;
    logic [74:0] exp_q[4][$];

    always #4 mclk = ~mclk;

    vqs_switch u_vqs_switch (.mclk(mclk), .rst_n(rst_n), .in_valid(in_valid),
        .in_first(in_first), .in_last(in_last), .in_len(in_len), .in_data(in_data),
        .in_ready(in_ready), .pkt_drop(pkt_drop), .tx_valid(tx_valid), .tx_first(tx_first),
        .tx_last(tx_last), .tx_port(tx_port), .tx_len(tx_len), .tx_data(tx_data),
        .tx_ready(tx_ready));
    vqs_card_sink u_vqs_card_sink (.mclk(mclk), .rst_n(rst_n), .mode(sink_mode),
        .tx_ready(tx_ready));

    task automatic check_frag(input logic [74:0] got, input logic [74:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_frag

    task automatic check_num(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_num

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Egress monitor: each copy is judged against its own port's queue
    always @(posedge mclk) begin
        cycles++;
        if (rst_n && pkt_drop === 1'b1) drops++;
        if (rst_n && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_q[tx_port].size() == 0) begin
                check_num({30'h0, tx_port}, 32'hFFFF_FFFF);
            end else begin
                check_frag({tx_first, tx_last, tx_len, tx_data}, exp_q[tx_port].pop_front());
            end
        end
        if (cycles == 30000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic send_frag(input logic f, input logic l, input logic [8:0] len,
                             input logic [63:0] d);
        int n;
        @(negedge mclk);
        in_valid = 1'b1;
        in_first = f;
        in_last = l;
        in_len = len;
        in_data = d;
        n = 0;
        while (in_ready !== 1'b1 && n < 500) begin
            @(negedge mclk);
            n++;
        end
        if (n == 500) check_num(n, 0);
        @(posedge mclk);
    endtask : send_frag

    // Released data lines toggle so a stale value is never mistaken for a fragment
    task automatic idle();
        @(negedge mclk);
        in_valid = 1'b0;
        in_data = ~in_data;
    endtask : idle

    task automatic send_pkt(input logic [63:0] hdr, input int nfrag, input logic [8:0] len,
                            input logic good);
        logic [3:0] dst;
        logic [63:0] d, e;
        logic [8:0] fl;
        dst = hdr[15] ? hdr[3:0] : 4'h1 << hdr[1:0];
        for (int i = 0; i < nfrag; i++) begin
            d = (i == 0) ? hdr : {48'hA5A5_0000_C3C3, 16'(i)};
            fl = (i == 0) ? len : 9'h040;
            send_frag(i == 0, i == nfrag - 1, fl, d);
            for (int p = 0; p < 4; p++) begin
                if (good && dst[p]) begin
                    e = d;
                    if (i == 0) begin
                        e[15] = 1'b0;
                        e[9:8] = 2'(p);
                    end
                    exp_q[p].push_back({i == 0, i == nfrag - 1, fl, e});
                end
            end
        end
        idle();
    endtask : send_pkt

    task automatic wait_drain();
        int n;
        n = 0;
        while (exp_q[0].size() + exp_q[1].size() + exp_q[2].size() + exp_q[3].size() > 0
               && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        check_num(exp_q[0].size() + exp_q[1].size() + exp_q[2].size() + exp_q[3].size(), 0);
    endtask : wait_drain

    task automatic t_unicast();
        sink_mode = 2'h0;
        for (int p = 0; p < 4; p++) send_pkt(64'h1234_5678_9ABC_7F00 | p, 1, 9'h040, 1'b1);
        send_pkt(64'h0000_0000_0000_0303, 1, 9'h180, 1'b1);
        wait_drain();
    endtask : t_unicast

    task automatic t_multi_frag();
        sink_mode = 2'h1;
        send_pkt(64'hFEDC_BA98_7654_0002, 4, 9'h180, 1'b1);
        send_pkt(64'h0F0F_0F0F_0F0F_0102, 2, 9'h041, 1'b1);
        wait_drain();
    endtask : t_multi_frag

    task automatic t_mcast();
        sink_mode = 2'h0;
        send_pkt(64'h0000_1111_0000_800F, 3, 9'h100, 1'b1);
        send_pkt(64'h2222_0000_0000_8005, 2, 9'h080, 1'b1);
        send_pkt(64'h3333_0000_0000_8002, 1, 9'h040, 1'b1);
        wait_drain();
    endtask : t_mcast

    task automatic t_bad_len();
        int d0;
        logic [8:0] bad [3] = '{9'h03F, 9'h181, 9'h000};
        for (int k = 0; k < 3; k++) begin
            d0 = drops;
            send_pkt(64'h0000_0000_0000_0001, 2, bad[k], 1'b0);
            repeat (4) @(negedge mclk);
            check_num(drops - d0, 1);
        end
        d0 = drops;
        send_pkt(64'h0000_0000_0000_8000, 1, 9'h040, 1'b0);
        repeat (4) @(negedge mclk);
        check_num(drops - d0, 1);
        d0 = drops;
        send_frag(1'b0, 1'b1, 9'h040, 64'h0000_0000_0000_0077);
        idle();
        repeat (4) @(negedge mclk);
        check_num(drops - d0, 1);
        wait_drain();
    endtask : t_bad_len

    task automatic t_credit();
        sink_mode = 2'h2;
        for (int k = 0; k < 8; k++) send_pkt(64'h5A00_0000_0000_0001 | (k << 32), 1, 9'h040, 1'b1);
        repeat (30) @(negedge mclk);
        check_num({31'h0, tx_valid}, 1);
        check_frag({tx_first, tx_last, tx_len, tx_data}, exp_q[1][0]);
        check_num({30'h0, tx_port}, 1);
        sink_mode = 2'h1;
        wait_drain();
    endtask : t_credit

    initial begin
        rst_n = 1'b0;
        in_valid = 1'b0;
        in_first = 1'b0;
        in_last = 1'b0;
        in_len = 9'h000;
        in_data = 64'h0000_0000_0000_0000;
        sink_mode = 2'h0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        t_unicast();
        t_multi_frag();
        t_mcast();
        t_bad_len();
        t_credit();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
